// file: uda_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

// Operation
// R1: firmware writes address after status stage
// R2: device address clears to zero on reset
// R3: function enable reads state, zero disables
// R4: packets accepted only while function enabled
// R5: firmware sets function enable after bus reset
// R6: enable register write-one sets endpoint mask
// R7: disable register write-one clears endpoint mask
// R8: same write-one behaviour for bus events
// R9: mask register reads current enables
// R10: bus resume mask resets enabled
// R11: endpoint pending when any cause flag set
// R12: endpoint pending held until cause cleared
// R13: status register reads pending endpoint flags
// R14: disabling frame start or wakeup removes it
// R15: clear register write-one clears event flags
// R16: suspend flagged after three ms idle
// R17: send-resume rising edge in suspend flags
// R18: frame start token raises its flag
// R19: interrupt output high while masked flag pending
// R20: end-of-reset flag is status only
module uda_ctrl #(
  parameter int IDLE_CYCLES = uda_pkg::SUSPEND_IDLE_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       resetn,
  // register port
  input  wire logic [uda_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [31:0]                reg_rdata,
  // endpoint cause flags, level, from the endpoint control/status logic
  input  wire logic [7:0]                 setup_received_flag,
  input  wire logic [7:0]                 bank0_received_flag,
  input  wire logic [7:0]                 bank1_received_flag,
  input  wire logic [7:0]                 in_transfer_done_flag,
  input  wire logic [7:0]                 stall_sent_flag,
  // bus events from the line logic, one-cycle pulses
  input  wire logic                       frame_start_token,
  input  wire logic                       bus_reset_done,
  // asynchronous inputs
  input  wire logic                       line_active,
  input  wire logic                       send_resume,
  // outputs
  output logic      [6:0]                 device_address_value,
  output logic                            function_enable,
  output logic                            packet_xfer_allowed,
  output logic                            suspended,
  output logic                            irq
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [6:0]                    addr_val;
    logic                          func_en;
    logic [uda_pkg::IRQ_W-1:0]     mask;
    logic [uda_pkg::NUM_EP-1:0]    ep_pend;
    logic [uda_pkg::EVT_W-1:0]     evt;
    logic                          act_s1;
    logic                          act_s2;
    logic                          rsm_s1;
    logic                          rsm_s2;
    logic                          rsm_prev;
    logic [uda_pkg::IDLE_CNT_W-1:0] idle_cnt;
    logic                          susp;
    logic                          irq;
    logic [31:0]                   rdata;
  } uda_state_type;

  localparam logic [uda_pkg::IDLE_CNT_W-1:0] IDLE_LAST =
    uda_pkg::IDLE_CNT_W'(IDLE_CYCLES - 1);

  uda_state_type state_ff;
  uda_state_type nxt_state;
  logic [uda_pkg::NUM_EP-1:0] ep_cause;

  // ==========================================================================
  // endpoint causes
  genvar g;
  generate
    for (g = 0; g < uda_pkg::NUM_EP; g++) begin : g_ep
      assign ep_cause[g] = setup_received_flag[g] | bank0_received_flag[g] | // R11
                           bank1_received_flag[g] | in_transfer_done_flag[g] |
                           stall_sent_flag[g];
    end
  endgenerate

  // ==========================================================================
  // next state
  always_comb begin
    logic                        wr_addr;
    logic                        wr_en;
    logic                        wr_dis;
    logic                        wr_clr;
    logic [uda_pkg::EVT_W-1:0]   ev_set;
    logic [uda_pkg::EVT_W-1:0]   ev_clr;
    logic [uda_pkg::IRQ_W-1:0]   pend;
    logic [uda_pkg::IRQ_W-1:0]   wbits;
    logic                        resume_seen;
    logic                        ext_edge;
    logic                        idle_hit;
    wr_addr     = reg_wr && (reg_addr == uda_pkg::OFF_FUNC_ADDR);
    wr_en       = reg_wr && (reg_addr == uda_pkg::OFF_IRQ_ENABLE);
    wr_dis      = reg_wr && (reg_addr == uda_pkg::OFF_IRQ_DISABL);
    wr_clr      = reg_wr && (reg_addr == uda_pkg::OFF_IRQ_CLEAR);
    wbits       = reg_wdata[uda_pkg::IRQ_W-1:0] & uda_pkg::MASK_WRITABLE;
    ev_set      = '0;
    ev_clr      = '0;
    nxt_state   = state_ff;

    // synchronisers: first stage read only by the second
    nxt_state.act_s1   = line_active;
    nxt_state.act_s2   = state_ff.act_s1;
    nxt_state.rsm_s1   = send_resume;
    nxt_state.rsm_s2   = state_ff.rsm_s1;
    nxt_state.rsm_prev = state_ff.rsm_s2;

    // address and function enable; R1 and R5 are firmware's duty
    if (wr_addr) begin
      nxt_state.addr_val = reg_wdata[uda_pkg::ADDR_VAL_LSB +: uda_pkg::ADDR_VAL_W];
      nxt_state.func_en  = reg_wdata[uda_pkg::FUNC_EN_BIT]; // R3
    end

    // mask: write one sets or clears, zero leaves alone
    if (wr_en) begin
      nxt_state.mask = state_ff.mask | wbits; // R6 R8
    end
    if (wr_dis) begin
      nxt_state.mask = state_ff.mask & ~wbits; // R7 R8 R14
    end

    // suspend detection on idle bus
    resume_seen = state_ff.susp && state_ff.act_s2;
    ext_edge    = state_ff.susp && state_ff.rsm_s2 && !state_ff.rsm_prev;
    idle_hit    = 1'b0;
    if (state_ff.act_s2 || bus_reset_done) begin
      nxt_state.idle_cnt = '0;
    end else if (!state_ff.susp) begin
      if (state_ff.idle_cnt >= IDLE_LAST) begin
        idle_hit           = 1'b1; // R16
        nxt_state.idle_cnt = '0;
      end else begin
        nxt_state.idle_cnt = state_ff.idle_cnt + 1'b1;
      end
    end
    if (idle_hit) begin
      nxt_state.susp = 1'b1; // R16
    end else if (resume_seen || bus_reset_done) begin
      nxt_state.susp = 1'b0;
    end

    // event flags: a set in the same cycle as a clear wins
    ev_set[uda_pkg::EV_SUSPEND]     = idle_hit; // R16
    ev_set[uda_pkg::EV_RESUME]      = resume_seen;
    ev_set[uda_pkg::EV_EXT_RESUME]  = ext_edge; // R17
    ev_set[uda_pkg::EV_FRAME_START] = frame_start_token; // R18
    ev_set[uda_pkg::EV_RESET_END]   = bus_reset_done; // R20
    ev_set[uda_pkg::EV_WAKEUP]      = resume_seen | bus_reset_done;
    if (wr_clr) begin
      ev_clr = reg_wdata[uda_pkg::EVT_LSB +: uda_pkg::EVT_W]; // R15
    end
    nxt_state.evt = (state_ff.evt & ~ev_clr) | ev_set; // R15

    // endpoint pending follows the sticky cause flags
    nxt_state.ep_pend = ep_cause; // R12

    // interrupt; end-of-reset carries no mask bit
    pend     = {state_ff.evt, state_ff.ep_pend};
    nxt_state.irq = |(pend & state_ff.mask & uda_pkg::MASK_WRITABLE); // R19 R20

    // read data valid only in the cycle after the strobe
    nxt_state.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        uda_pkg::OFF_FUNC_ADDR: begin
          nxt_state.rdata[uda_pkg::ADDR_VAL_LSB +: uda_pkg::ADDR_VAL_W] = state_ff.addr_val;
          nxt_state.rdata[uda_pkg::FUNC_EN_BIT] = state_ff.func_en; // R3
        end
        uda_pkg::OFF_IRQ_MASK: begin
          nxt_state.rdata[uda_pkg::IRQ_W-1:0] = state_ff.mask; // R9
        end
        uda_pkg::OFF_IRQ_STATUS: begin
          nxt_state.rdata[uda_pkg::IRQ_W-1:0] = pend; // R13
        end
        default: begin
          nxt_state.rdata = '0;
        end
      endcase
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff          <= '0;
      state_ff.addr_val <= uda_pkg::RST_ADDR_VAL; // R2
      state_ff.func_en  <= uda_pkg::RST_FUNC_EN;
      state_ff.mask     <= uda_pkg::RST_IRQ_MASK; // R10
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================================
  // outputs
  assign reg_rdata            = state_ff.rdata;
  assign device_address_value = state_ff.addr_val;
  assign function_enable      = state_ff.func_en;
  assign packet_xfer_allowed  = state_ff.func_en; // R4
  assign suspended            = state_ff.susp;
  assign irq                  = state_ff.irq;

endmodule

`default_nettype wire

// file: uda_pkg.sv
package uda_pkg;

  // ==========================================================================
  // register map
  localparam int          ADDR_W         = 12;
  localparam logic [11:0] OFF_FUNC_ADDR  = 12'h008;
  localparam logic [11:0] OFF_IRQ_ENABLE = 12'h010;
  localparam logic [11:0] OFF_IRQ_DISABL = 12'h014;
  localparam logic [11:0] OFF_IRQ_MASK   = 12'h018;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h01C;
  localparam logic [11:0] OFF_IRQ_CLEAR  = 12'h020;

  // ==========================================================================
  // field layout
  localparam int ADDR_VAL_LSB   = 0;
  localparam int ADDR_VAL_W     = 7;
  localparam int FUNC_EN_BIT    = 8;
  localparam int NUM_EP         = 8;
  localparam int EVT_LSB        = 8;
  localparam int EVT_W          = 6;
  localparam int IRQ_W          = 14;
  // event index inside the event field
  localparam int EV_SUSPEND     = 0;
  localparam int EV_RESUME      = 1;
  localparam int EV_EXT_RESUME  = 2;
  localparam int EV_FRAME_START = 3;
  localparam int EV_RESET_END   = 4;
  localparam int EV_WAKEUP      = 5;

  // ==========================================================================
  // reset values
  localparam logic [6:0]  RST_ADDR_VAL   = 7'h00;
  localparam logic        RST_FUNC_EN    = 1'b1;
  localparam logic [13:0] RST_IRQ_MASK   = 14'h1200;
  // bits that software may change in the mask; end-of-reset has no mask
  localparam logic [13:0] MASK_WRITABLE  = 14'h2FFF;

  // ==========================================================================
  // timing
  localparam int CLK_HZ          = 40_000_000;
  localparam int SUSPEND_IDLE_MS = 3;
  localparam int SUSPEND_IDLE_CYC = SUSPEND_IDLE_MS * (CLK_HZ / 1000);
  localparam int IDLE_CNT_W      = 17;

endpackage

// file: uda_ctrl_props.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// register port checks
module uda_ctrl_chk (
  input wire logic [31:0]                reg_rdata,
  input wire logic [31:0]                reg_wdata,
  input wire logic [uda_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [6:0]                 device_address_value,
  input wire logic                       clk,
  input wire logic                       resetn,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic                       function_enable,
  input wire logic                       packet_xfer_allowed
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_wr(logic [11:0] a, logic [13:0] d);
    reg_wr && reg_addr == a && reg_wdata[13:0] == d;
  endsequence
  sequence s_rd(logic [11:0] a);
    reg_rd && reg_addr == a;
  endsequence
  chk_addr_reset_zero: assert property ($rose(resetn) |-> device_address_value == 7'h00)
    else $error("address not zero after reset");
  chk_xfer_tracks_en: assert property (packet_xfer_allowed == function_enable)
    else $error("transfer permission differs from enable");
  chk_fen_write_zero: assert property (reg_wr && reg_addr == uda_pkg::OFF_FUNC_ADDR
    && !reg_wdata[8] |=> !function_enable) else $error("enable not cleared by write");
  chk_addr_read_back: assert property (s_rd(uda_pkg::OFF_FUNC_ADDR) |=> reg_rdata ==
    {23'h0, $past(function_enable), 1'b0, $past(device_address_value)}) else $error("bad read");
  chk_wo_read_zero: assert property (s_rd(uda_pkg::OFF_IRQ_ENABLE)
    or s_rd(uda_pkg::OFF_IRQ_DISABL) |=> reg_rdata == 32'h0) else $error("write-only read");
  chk_mask_after_en: assert property (s_wr(uda_pkg::OFF_IRQ_ENABLE, 14'h3FFF)
    ##1 s_rd(uda_pkg::OFF_IRQ_MASK) |=> reg_rdata == 32'h3FFF) else $error("mask after set");
  chk_mask_after_dis: assert property (s_wr(uda_pkg::OFF_IRQ_DISABL, 14'h3FFF)
    ##1 s_rd(uda_pkg::OFF_IRQ_MASK) |=> reg_rdata == 32'h1000) else $error("mask after clr");
  chk_mask_bits_fixed: assert property (s_rd(uda_pkg::OFF_IRQ_MASK) |=>
    reg_rdata[31:14] == 18'h0 && reg_rdata[12]) else $error("fixed mask bits wrong");
endmodule
bind uda_ctrl uda_ctrl_chk u_chk (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .device_address_value(device_address_value), .function_enable(function_enable),
  .packet_xfer_allowed(packet_xfer_allowed));
`default_nettype wire

// file: uda_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// bus side: tokens, reset end and line activity
module uda_host_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sof_go,
  input wire logic rst_go,
  input wire logic bus_idle,
  output logic     frame_start_token,
  output logic     bus_reset_done,
  output logic     line_active
);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      frame_start_token <= 1'b0;
      bus_reset_done <= 1'b0;
      line_active <= 1'b1;
    end else begin
      frame_start_token <= sof_go;
      bus_reset_done <= rst_go;
      line_active <= !bus_idle;
    end
  end
endmodule
`default_nettype wire

// file: tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, sof_go = 0, rst_go = 0;
  logic        bus_idle = 0, send_resume = 0, frame_start_token, bus_reset_done, line_active;
  logic        suspended, irq, function_enable, packet_xfer_allowed;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
  logic [7:0]  cause [5] = '{default: 8'h00};
  logic [6:0]  device_address_value;
  logic [13:0] mask_m = 14'h1200, e;
  int          miscompares = 0, checked = 0, cycles = 0;
  always #12.5 clk = ~clk;
  // hang guard, run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      report_and_stop;
    end
  end
  uda_ctrl #(.IDLE_CYCLES(20)) dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .setup_received_flag(cause[0]), .bank0_received_flag(cause[1]),
    .bank1_received_flag(cause[2]), .in_transfer_done_flag(cause[3]),
    .stall_sent_flag(cause[4]), .frame_start_token(frame_start_token),
    .bus_reset_done(bus_reset_done), .line_active(line_active), .send_resume(send_resume),
    .device_address_value(device_address_value), .function_enable(function_enable),
    .packet_xfer_allowed(packet_xfer_allowed), .suspended(suspended), .irq(irq));
  uda_host_model host (.clk(clk), .resetn(resetn), .sof_go(sof_go), .rst_go(rst_go),
    .bus_idle(bus_idle), .frame_start_token(frame_start_token),
    .bus_reset_done(bus_reset_done), .line_active(line_active));
  // ==========================================
  // bus tasks; a write leaves its strobe up until the next task or idle
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  task automatic idle;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, x);
  endtask
  task automatic st(input logic [13:0] x);
    idle;
    repeat (4) @(posedge clk);
    rdchk(uda_pkg::OFF_IRQ_STATUS, {18'h0, x});
    chk({31'h0, irq}, {31'h0, |(x & mask_m & 14'h2FFF)});
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    void'($urandom(33794));
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rdchk(uda_pkg::OFF_FUNC_ADDR, 32'h0000_0100);
    rdchk(uda_pkg::OFF_IRQ_MASK, 32'h0000_1200);
    wr(uda_pkg::OFF_IRQ_MASK, 32'hFFFF_FFFF);
    rdchk(uda_pkg::OFF_IRQ_MASK, 32'h0000_1200);
    rdchk(12'h00C, 32'h0);
    rdchk(uda_pkg::OFF_IRQ_ENABLE, 32'h0);
    v = $urandom;
    wr(uda_pkg::OFF_FUNC_ADDR, {25'h0, v[6:0]});
    rdchk(uda_pkg::OFF_FUNC_ADDR, {25'h0, v[6:0]});
    chk({30'h0, function_enable, packet_xfer_allowed}, 32'h0);
    wr(uda_pkg::OFF_FUNC_ADDR, 32'h0000_0100);
    wr(uda_pkg::OFF_IRQ_ENABLE, 32'h0000_3FFF);
    rdchk(uda_pkg::OFF_IRQ_MASK, 32'h0000_3FFF);
    wr(uda_pkg::OFF_IRQ_DISABL, 32'h0000_3FFF);
    rdchk(uda_pkg::OFF_IRQ_MASK, 32'h0000_1000);
    mask_m = 14'h1000;
    for (int i = 0; i < 12; i++) begin
      e = $urandom;
      v = $urandom;
      wr(uda_pkg::OFF_IRQ_ENABLE, {18'h0, e});
      wr(uda_pkg::OFF_IRQ_DISABL, {18'h0, v[13:0]});
      mask_m = (mask_m | (e & 14'h2FFF)) & ~(v[13:0] & 14'h2FFF);
      rdchk(uda_pkg::OFF_IRQ_MASK, {18'h0, mask_m});
    end
    wr(uda_pkg::OFF_IRQ_ENABLE, 32'h0000_28FF);
    mask_m = mask_m | 14'h28FF;
    for (int k = 0; k < 5; k++) begin
      v = $urandom;
      idle;
      cause[k] <= v[7:0];
      st({6'h0, v[7:0]});
      @(posedge clk);
      cause[k] <= 8'h00;
      st(14'h0);
    end
    @(posedge clk);
    sof_go <= 1'b1;
    @(posedge clk);
    sof_go <= 1'b0;
    st(14'h0800);
    wr(uda_pkg::OFF_IRQ_CLEAR, 32'h0000_37FF);
    st(14'h0800);
    wr(uda_pkg::OFF_IRQ_DISABL, 32'h0000_0800);
    mask_m[11] = 1'b0;
    st(14'h0800);
    wr(uda_pkg::OFF_IRQ_CLEAR, 32'h0000_0800);
    st(14'h0);
    @(posedge clk);
    rst_go <= 1'b1;
    @(posedge clk);
    rst_go <= 1'b0;
    st(14'h3000);
    wr(uda_pkg::OFF_IRQ_CLEAR, 32'h0000_3F00);
    st(14'h0);
    @(posedge clk);
    bus_idle <= 1'b1;
    for (int n = 0; n < 60 && suspended !== 1'b1; n++) @(posedge clk);
    st(14'h0100);
    @(posedge clk);
    send_resume <= 1'b1;
    st(14'h0500);
    @(posedge clk);
    bus_idle <= 1'b0;
    st(14'h2700);
    chk({31'h0, suspended}, 32'h0);
    report_and_stop;
  end
endmodule
`default_nettype wire
